// File: sim/uec_host_model.sv
// Purpose: Host side stand-in that issues tokens and engine events.
// Assumes: Driven by bench calls; every change lands on a rising edge.
// Notes:   A token stays up until tok_off; done and SETUP events are one-cycle pulses.
`timescale 1ns/1ps
module uec_host_model
    import uec_pkg::*;
#(
    parameter int N = 2 * NUM_EP
)
(
    // Clock
    input  wire logic         aclk,
    // Engine events toward the block
    output logic [N-1:0]      token,
    output logic [N-1:0]      fifo_ready,
    output logic [N-1:0]      xact_idle,
    output logic [N-1:0]      pkt_done,
    output logic [N-1:0]      xfer_done,
    output logic [NUM_EP-1:0] setup_rx,
    output logic              frame_odd
);
    initial
    begin
        token      = '0;
        fifo_ready = '1;
        xact_idle  = '1;
        pkt_done   = '0;
        xfer_done  = '0;
        setup_rx   = '0;
        frame_odd  = 1'b0;
    end

    // Token is held until tok_off so the answer can be looked at
    task automatic tok_on(input int i);
        @(posedge aclk);
        token <= N'(1) << i;
        @(negedge aclk);
    endtask : tok_on

    task automatic tok_off();
        @(posedge aclk);
        token <= '0;
    endtask : tok_off

    // Kind 0 packet done, 1 transfer done, else SETUP on endpoint number i (IN and OUT)
    task automatic pulse(input int k, input int i);
        logic [N-1:0] m;
        m = N'(1) << i;
        @(posedge aclk);
        case (k)
            0: pkt_done <= m;
            1: xfer_done <= m;
            default: setup_rx <= m[NUM_EP-1:0];
        endcase
        @(posedge aclk);
        pkt_done  <= '0;
        xfer_done <= '0;
        setup_rx  <= '0;
        @(negedge aclk);
    endtask : pulse

    task automatic set_lv(input logic [N-1:0] idle, input logic odd);
        @(posedge aclk);
        xact_idle <= idle;
        frame_odd <= odd;
    endtask : set_lv
endmodule : uec_host_model

// File: sim/usb_device_endpoint_control_test.sv
// Purpose: Self-checking bench for the endpoint control block.
// Assumes: Word-wide AXI4-Lite accesses; host model makes engine events.
// Notes:   Expected values come from bench functions and package constants.
`timescale 1ns/1ps
module usb_device_endpoint_control_test
    import uec_pkg::*;
;
    localparam int N = 2 * NUM_EP;
    localparam logic [31:0] M_ARM = 32'h1 << B_ARM;
    localparam logic [31:0] M_DIS = 32'h1 << B_DIS;
    localparam logic [31:0] M_ODD = 32'h1 << B_SET_ODD;
    localparam logic [31:0] M_EVEN = 32'h1 << B_SET_EVEN;
    localparam logic [31:0] M_NSET = 32'h1 << B_NAK_SET_STROBE;
    localparam logic [31:0] M_NCLR = 32'h1 << B_NAK_CLEAR_STROBE;
    localparam logic [31:0] M_STALL = 32'h1 << B_STALL;
    localparam logic [31:0] M_SNOOP = 32'h1 << B_SNOOP;
    localparam logic [31:0] M_NAKST = 32'h1 << B_NAK_STATE;
    localparam logic [31:0] M_PAR = 32'h1 << B_PAR;
    localparam logic [31:0] M_ACT = 32'h1 << B_ACT;
    localparam logic [31:0] M_ISO = 32'(TYPE_ISO) << B_TYPE_LO;
    localparam logic [31:0] M_BULK = 32'(TYPE_BULK) << B_TYPE_LO;
    logic                aclk, aresetn;
    logic [11:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]         s_axi_wdata, s_axi_rdata;
    logic [3:0]          s_axi_wstrb;
    logic [1:0]          s_axi_bresp, s_axi_rresp;
    logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                s_axi_arvalid, s_axi_arready;
    logic                s_axi_rvalid, s_axi_rready;
    logic [N-1:0]        token, fifo_ready, xact_idle, pkt_done, xfer_done;
    logic [NUM_EP-1:0]   setup_rx;
    logic                frame_odd;
    uec_hs_t             hs_answer [N];
    logic [N-1:0]        send_data, zero_len, data_pid1, crc_skip;
    logic [N-1:0]        ep_armed, ep_irq;
    logic [N*11-1:0]     pkt_bytes;
    logic [NUM_EP*4-1:0] tx_fifo_select;
    int                  mismatches, cmp_count, wd;

    uec_ep_ctrl uec_ep_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .token(token),
        .fifo_ready(fifo_ready), .xact_idle(xact_idle),
        .pkt_done(pkt_done), .xfer_done(xfer_done), .setup_rx(setup_rx),
        .frame_odd(frame_odd), .hs_answer(hs_answer),
        .send_data(send_data), .zero_len(zero_len),
        .data_pid1(data_pid1), .crc_skip(crc_skip), .ep_armed(ep_armed),
        .pkt_bytes(pkt_bytes), .tx_fifo_select(tx_fifo_select),
        .ep_irq(ep_irq));

    uec_host_model uec_host_model_inst (.aclk(aclk), .token(token),
        .fifo_ready(fifo_ready), .xact_idle(xact_idle),
        .pkt_done(pkt_done), .xfer_done(xfer_done),
        .setup_rx(setup_rx), .frame_odd(frame_odd));

    function automatic logic [11:0] inc(input int n);
        return 12'(IN_CTL_BASE + EP_STRIDE * n);
    endfunction : inc

    function automatic logic [11:0] onc(input int n);
        return 12'(OUT_CTL_BASE + EP_STRIDE * n);
    endfunction : onc

    function automatic logic [31:0] mpl_bytes(input int c);
        return 32'h40 >> c;
    endfunction : mpl_bytes

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task automatic tick();
        wd++;
        if (wd > 200)
        begin
            mismatches++;
            $display("[FAIL] %0t wait count %h exp %h", $time, wd, 200);
            give_verdict();
        end
    endtask : tick

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // Address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tick();
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_awvalid || s_axi_wvalid);
        while (s_axi_bvalid !== 1'b1)
        begin
            @(negedge aclk);
            tick();
        end
        chk(32'(s_axi_bresp), 32'h0);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic rdm(input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        logic [31:0] d;
        wd = 0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(negedge aclk);
            tick();
        end
        while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1)
        begin
            @(negedge aclk);
            tick();
        end
        d = s_axi_rdata;
        chk(32'(s_axi_rresp), 32'h0);
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        chk(d & m, e);
    endtask : rdm

    // Answer, data and empty-packet outputs seen while the token is up
    task automatic tok(input int i, input uec_hs_t e, input logic sd,
                       input logic zl);
        uec_host_model_inst.tok_on(i);
        chk(32'({hs_answer[i], send_data[i], zero_len[i]}), 32'({e, sd, zl}));
        uec_host_model_inst.tok_off();
    endtask : tok

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial
    begin
        logic [31:0] d;
        int          r;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        {mismatches, cmp_count, wd} = '0;
        void'($urandom(32'hda0d615d));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdm(inc(0), '1, EP0_RESET);
        rdm(onc(0), '1, EP0_RESET);
        rdm(inc(1), '1, EPN_RESET);
        rdm(12'hffc, '1, 32'h0);
        axi_wr(inc(1), M_ACT | M_BULK | M_NSET);
        rdm(inc(1), '1, M_ACT | M_BULK | M_NAKST);
        tok(1, HS_NAK, 1'b0, 1'b0);
        axi_wr(inc(1), M_ACT | M_BULK | M_NCLR);
        tok(1, HS_NONE, 1'b1, 1'b0);
        axi_wr(inc(1), M_ACT | M_BULK | M_STALL | M_NSET);
        axi_wr(GNAK_OFFSET, 32'h1);
        tok(1, HS_STALL, 1'b0, 1'b0);
        axi_wr(GNAK_OFFSET, 32'h0);
        axi_wr(inc(1), M_ACT | M_BULK);
        tok(1, HS_NAK, 1'b0, 1'b0);
        axi_wr(inc(2), M_ACT | M_STALL);
        axi_wr(inc(2), M_ACT);
        tok(2, HS_STALL, 1'b0, 1'b0);
        uec_host_model_inst.pulse(2, 2);
        tok(2, HS_NONE, 1'b1, 1'b0);
        axi_wr(inc(0), M_STALL);
        axi_wr(onc(0), M_STALL);
        tok(6, HS_STALL, 1'b0, 1'b0);
        uec_host_model_inst.pulse(2, 0);
        rdm(inc(0), M_STALL, 32'h0);
        rdm(onc(0), M_STALL, 32'h0);
        for (r = 0; r < 4; r++)
        begin
            axi_wr(inc(3), M_ACT | (32'(r) << B_TYPE_LO));
            rdm(inc(3), '1, M_ACT | (32'(r) << B_TYPE_LO));
        end
        axi_wr(inc(0), 32'h000c_0000);
        rdm(inc(0), '1, EP0_RESET);
        for (r = 0; r < 4; r++)
        begin
            axi_wr(inc(0), 32'(r));
            chk(32'(pkt_bytes[10:0]), mpl_bytes(r));
            chk(32'(pkt_bytes[76:66]), mpl_bytes(r));
            rdm(onc(0), '1, EP0_RESET | 32'(r));
        end
        d = $urandom & 32'h03c0_07ff;
        axi_wr(inc(3), M_ACT | M_BULK | d);
        chk(32'(pkt_bytes[43:33]), d & 32'h7ff);
        chk(32'(tx_fifo_select[15:12]), d >> B_TXF_LO);
        axi_wr(inc(4), M_ACT | M_ISO | M_ODD);
        rdm(inc(4), M_PAR, M_PAR);
        uec_host_model_inst.set_lv('1, 1'b1);
        tok(4, HS_NONE, 1'b1, 1'b0);
        uec_host_model_inst.set_lv('1, 1'b0);
        tok(4, HS_NONE, 1'b0, 1'b1);
        axi_wr(inc(4), M_ACT | M_ISO | M_EVEN);
        tok(4, HS_NONE, 1'b1, 1'b0);
        axi_wr(inc(5), M_ACT | M_BULK | M_ODD);
        chk(32'(data_pid1[5]), 32'h1);
        axi_wr(inc(5), M_ACT | M_BULK | M_EVEN);
        chk(32'(data_pid1[5]), 32'h0);
        uec_host_model_inst.pulse(0, 5);
        chk(32'(data_pid1[5]), 32'h1);
        axi_wr(inc(3), M_BULK | M_NSET | M_STALL);
        tok(3, HS_NONE, 1'b0, 1'b0);
        axi_wr(onc(1), M_ACT | M_BULK | M_SNOOP);
        chk(32'(crc_skip[7]), 32'h1);
        axi_wr(onc(1), M_ACT | M_BULK | M_NSET);
        chk(32'(crc_skip[7]), 32'h0);
        tok(7, HS_NAK, 1'b0, 1'b0);
        axi_wr(onc(0), M_DIS);
        rdm(onc(0), '1, EP0_RESET | 32'h3);
        uec_host_model_inst.set_lv(~(N'(1) << 5), 1'b0);
        axi_wr(inc(5), M_ARM | M_ACT | M_BULK);
        chk(32'(ep_armed[5]), 32'h1);
        axi_wr(inc(5), M_ACT | M_BULK);
        chk(32'(ep_armed[5]), 32'h1);
        axi_wr(IRQ_EN_BASE + 12'h014, 32'h3);
        axi_wr(inc(5), M_ACT | M_BULK | M_DIS);
        rdm(inc(5), M_ARM | M_DIS, M_ARM | M_DIS);
        uec_host_model_inst.set_lv('1, 1'b0);
        wd = 0;
        while (ep_armed[5] !== 1'b0)
        begin
            @(negedge aclk);
            tick();
        end
        rdm(inc(5), M_ARM | M_DIS, 32'h0);
        rdm(FLAG_BASE + 12'h014, 32'h3, 32'h2);
        chk(32'(ep_irq[5]), 32'h1);
        axi_wr(FLAG_BASE + 12'h014, 32'h2);
        chk(32'(ep_irq[5]), 32'h0);
        axi_wr(IRQ_EN_BASE + 12'h014, 32'h1);
        axi_wr(inc(5), M_ARM | M_ACT | M_BULK);
        uec_host_model_inst.pulse(1, 5);
        chk(32'(ep_armed[5]), 32'h0);
        rdm(FLAG_BASE + 12'h014, 32'h3, 32'h1);
        chk(32'(ep_irq[5]), 32'h1);
        axi_wr(12'hffc, $urandom);
        rdm(12'hffc, '1, 32'h0);
        give_verdict();
    end
endmodule : usb_device_endpoint_control_test

// File: src/uec_ep_ctrl.sv
// Purpose: Per-endpoint control registers and token answer of a USB device.
// Assumes: Software issues whole-word accesses; the engine gives one-cycle
//          event pulses per endpoint.
// Notes:   Index 0..5 is IN ep0..5, index 6..11 is OUT ep0..5.
`timescale 1ns/1ps
module uec_ep_ctrl
    import uec_pkg::*;
#(
    parameter int N = 2 * NUM_EP
)
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite slave
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Engine events, one bit per endpoint index; setup_rx one bit per endpoint number, frame_odd shared
    input  wire logic [N-1:0]      token,
    input  wire logic [N-1:0]      fifo_ready,
    input  wire logic [N-1:0]      xact_idle,
    input  wire logic [N-1:0]      pkt_done,
    input  wire logic [N-1:0]      xfer_done,
    input  wire logic [NUM_EP-1:0] setup_rx,
    input  wire logic              frame_odd,
    // Per-endpoint answer and settings
    output uec_hs_t                hs_answer [N],
    output logic [N-1:0]           send_data,
    output logic [N-1:0]           zero_len,
    output logic [N-1:0]           data_pid1,
    output logic [N-1:0]           crc_skip,
    output logic [N-1:0]           ep_armed,
    output logic [N*11-1:0]        pkt_bytes,
    output logic [NUM_EP*4-1:0]    tx_fifo_select,
    output logic [N-1:0]           ep_irq
);
    // Stored fields
    logic [N-1:0]       ep_arm, ep_disable_req, nak_state, stall, snoop;
    logic [N-1:0]       parity, ep_active, ep_disabled_flag, xfer_done_flag;
    logic [N-1:0]       ep_disabled_irq_en, xfer_done_irq_en;
    logic [1:0]         ep_transfer_type [N];
    logic [10:0]        max_pkt_len [N];
    logic [3:0]         txf [N];
    logic               global_in_nak_state, global_out_nak_state;

    function automatic logic [10:0] ep0_bytes(input logic [1:0] code);
        case (code)
            2'h0:    ep0_bytes = 11'h040;
            2'h1:    ep0_bytes = 11'h020;
            2'h2:    ep0_bytes = 11'h010;
            default: ep0_bytes = 11'h008;
        endcase
    endfunction : ep0_bytes

    // Write channel: take address and data in either order
    logic [11:0] aw_q;
    logic [31:0] w_q;
    logic        aw_have, w_have;
    wire         do_wr = aw_have && w_have && !s_axi_bvalid;
    assign s_axi_awready = !aw_have;
    assign s_axi_wready  = !w_have;
    assign s_axi_bresp   = 2'h0;
    assign s_axi_rresp   = 2'h0;
    assign s_axi_arready = !s_axi_rvalid;
    wire         full_word = (s_axi_wstrb == 4'hf);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b0;
            aw_q         <= 12'h000;
            w_q          <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid && !aw_have)
            begin
                aw_q    <= s_axi_awaddr;
                aw_have <= 1'b1;
            end
            if (s_axi_wvalid && !w_have)
            begin
                w_q    <= full_word ? s_axi_wdata : 32'h0;
                w_have <= 1'b1;
            end
            if (do_wr)
            begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    wire gnak_wr = do_wr && aw_q == GNAK_OFFSET;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            global_in_nak_state  <= 1'b0;
            global_out_nak_state <= 1'b0;
        end
        else if (gnak_wr)
        begin
            global_in_nak_state  <= w_q[0];
            global_out_nak_state <= w_q[1];
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_ep
            localparam bit IS_OUT = (i >= NUM_EP);
            localparam int EPN    = IS_OUT ? i - NUM_EP : i;
            localparam bit IS_EP0 = (EPN == 0);
            localparam logic [11:0] CTL_A =
                (IS_OUT ? OUT_CTL_BASE : IN_CTL_BASE) + 12'(EPN) * EP_STRIDE;
            wire        wr_ctl = do_wr && aw_q == CTL_A;
            wire        wr_ien = do_wr && aw_q == IRQ_EN_BASE + 12'(i*4);
            wire        wr_flg = do_wr && aw_q == FLAG_BASE + 12'(i*4);
            wire [31:0] d      = w_q;
            wire        is_ctl = IS_EP0 || ep_transfer_type[i] == TYPE_CTRL;
            wire        is_iso = !IS_EP0 && ep_transfer_type[i] == TYPE_ISO;
            wire        setup  = setup_rx[EPN];
            wire        gnak   = IS_OUT ? global_out_nak_state
                                        : global_in_nak_state;
            wire        dis_done = ep_disable_req[i] && xact_idle[i];

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    ep_arm[i]             <= 1'b0;
                    ep_disable_req[i]     <= 1'b0;
                    nak_state[i]          <= 1'b0;
                    stall[i]              <= 1'b0;
                    snoop[i]              <= 1'b0;
                    parity[i]             <= 1'b0;
                    ep_active[i]          <= IS_EP0;
                    ep_transfer_type[i]   <= TYPE_CTRL;
                    max_pkt_len[i]        <= 11'h000;
                    txf[i]                <= 4'h0;
                    ep_disabled_flag[i]   <= 1'b0;
                    xfer_done_flag[i]     <= 1'b0;
                    ep_disabled_irq_en[i] <= 1'b0;
                    xfer_done_irq_en[i]   <= 1'b0;
                end
                else
                begin
                    // Hardware clear first, software set after
                    if (dis_done || xfer_done[i])
                        ep_arm[i] <= 1'b0;
                    if (wr_ctl && d[B_ARM])
                        ep_arm[i] <= 1'b1;
                    if (dis_done)
                        ep_disable_req[i] <= 1'b0;
                    else if (wr_ctl && d[B_DIS] && !(IS_OUT && IS_EP0))
                        ep_disable_req[i] <= 1'b1;
                    if (wr_ctl && d[B_NAK_SET_STROBE])
                        nak_state[i] <= 1'b1;
                    else if (wr_ctl && d[B_NAK_CLEAR_STROBE])
                        nak_state[i] <= 1'b0;
                    if (wr_ctl && !IS_EP0 && (d[B_SET_ODD] || d[B_SET_EVEN]))
                        parity[i] <= d[B_SET_ODD];
                    else if (pkt_done[i] && !is_iso)
                        parity[i] <= !parity[i];
                    // STALL: set by software; clear path depends on type
                    if (wr_ctl && d[B_STALL])
                        stall[i] <= 1'b1;
                    else if (setup && is_ctl)
                        stall[i] <= 1'b0;
                    else if (wr_ctl && !is_ctl)
                        stall[i] <= 1'b0;
                    if (wr_ctl && !IS_EP0)
                    begin
                        ep_active[i]        <= d[B_ACT];
                        ep_transfer_type[i] <= d[B_TYPE_LO +: 2];
                        max_pkt_len[i]      <= d[10:0];
                    end
                    else if (wr_ctl && !IS_OUT)
                        max_pkt_len[i] <= {9'h000, d[1:0]};
                    if (wr_ctl && !IS_OUT)
                        txf[i] <= d[B_TXF_LO +: 4];
                    if (wr_ctl && IS_OUT)
                        snoop[i] <= d[B_SNOOP];
                    if (wr_ien)
                    begin
                        ep_disabled_irq_en[i] <= d[B_DISF];
                        xfer_done_irq_en[i]   <= d[B_DONEF];
                    end
                    // Set wins over write-one-to-clear
                    if (dis_done)
                        ep_disabled_flag[i] <= 1'b1;
                    else if (wr_flg && d[B_DISF])
                        ep_disabled_flag[i] <= 1'b0;
                    if (xfer_done[i])
                        xfer_done_flag[i] <= 1'b1;
                    else if (wr_flg && d[B_DONEF])
                        xfer_done_flag[i] <= 1'b0;
                end
            end

            // Token answer: inactive silent, STALL over NAK
            wire act = ep_active[i] && token[i];
            wire nak = nak_state[i] || gnak || !fifo_ready[i];
            wire par_ok = !is_iso || parity[i] == frame_odd;
            assign hs_answer[i] = !act ? HS_NONE :
                                  stall[i] ? HS_STALL :
                                  nak ? HS_NAK : HS_NONE;
            assign send_data[i] = act && !stall[i] && !nak && !IS_OUT
                                  && par_ok;
            assign zero_len[i]  = act && !stall[i] && !nak && !IS_OUT
                                  && !par_ok;
            assign data_pid1[i] = parity[i];
            assign crc_skip[i]  = IS_OUT && snoop[i];
            assign ep_armed[i]  = ep_arm[i];
            assign pkt_bytes[i*11 +: 11] = IS_EP0 ?
                ep0_bytes(max_pkt_len[IS_OUT ? 0 : i][1:0]) :
                max_pkt_len[i];
            assign ep_irq[i] = (ep_disabled_flag[i] && ep_disabled_irq_en[i])
                || (xfer_done_flag[i] && xfer_done_irq_en[i]);
            if (!IS_OUT)
            begin : g_txf
                assign tx_fifo_select[i*4 +: 4] = txf[i];
            end
        end
    endgenerate

    // Read decode: strobes read zero
    function automatic logic [31:0] ctl_word(input int k);
        logic [31:0] v;
        logic        e0;
        v  = 32'h0;
        e0 = (k % NUM_EP) == 0;
        v[B_ARM]  = ep_arm[k];
        v[B_DIS]  = ep_disable_req[k];
        v[B_STALL] = stall[k];
        v[B_NAK_STATE] = nak_state[k];
        v[B_ACT]  = ep_active[k];
        if (k >= NUM_EP)
            v[B_SNOOP] = snoop[k];
        else
            v[B_TXF_LO +: 4] = txf[k];
        if (!e0)
        begin
            v[B_TYPE_LO +: 2] = ep_transfer_type[k];
            v[B_PAR] = parity[k];
            v[10:0]  = max_pkt_len[k];
        end
        else
            v[1:0] = max_pkt_len[k >= NUM_EP ? 0 : k][1:0];
        ctl_word = v;
    endfunction : ctl_word

    logic [31:0] rd_val;
    always_comb
    begin
        rd_val = 32'h0;
        for (int k = 0; k < N; k++)
        begin
            if (s_axi_araddr == ((k >= NUM_EP ? OUT_CTL_BASE : IN_CTL_BASE)
                + 12'(k % NUM_EP) * EP_STRIDE))
                rd_val = ctl_word(k);
            if (s_axi_araddr == IRQ_EN_BASE + 12'(k*4))
                rd_val = {30'h0, ep_disabled_irq_en[k], xfer_done_irq_en[k]};
            if (s_axi_araddr == FLAG_BASE + 12'(k*4))
                rd_val = {30'h0, ep_disabled_flag[k], xfer_done_flag[k]};
        end
        if (s_axi_araddr == GNAK_OFFSET)
            rd_val = {30'h0, global_out_nak_state, global_in_nak_state};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    a_stall_over_nak: assert property (@(posedge aclk)
        disable iff (!aresetn)
        token[NUM_EP] && stall[NUM_EP] |-> hs_answer[NUM_EP] == HS_STALL)
        else $error("stall not answered");
    a_setup_clears_stall: assert property (@(posedge aclk)
        disable iff (!aresetn)
        setup_rx[0] && !(do_wr && aw_q == IN_CTL_BASE)
        |=> !stall[0])
        else $error("setup did not clear stall");
    a_nak_set_strobe: assert property (@(posedge aclk)
        disable iff (!aresetn)
        do_wr && aw_q == IN_CTL_BASE + EP_STRIDE && w_q[B_NAK_SET_STROBE]
        |=> nak_state[1])
        else $error("set nak missed");
    a_parity_strobe: assert property (@(posedge aclk)
        disable iff (!aresetn)
        do_wr && aw_q == IN_CTL_BASE + 12'(5) * EP_STRIDE
        && w_q[B_SET_ODD] |=> parity[5])
        else $error("odd strobe missed");
    a_ep0_active: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ep_active[0] && ep_active[NUM_EP])
        else $error("ep0 inactive");
    a_out0_no_dis: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !ep_disable_req[NUM_EP])
        else $error("out ep0 disable set");
    a_dis_flag_rise: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ep_disable_req[5] && xact_idle[5] && !(do_wr && w_q[B_ARM])
        |=> ep_disabled_flag[5] && !ep_disable_req[5] && !ep_arm[5])
        else $error("disable not completed");
    a_inactive_silent: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !ep_active[3] |-> hs_answer[3] == HS_NONE && !send_data[3]
        && !zero_len[3])
        else $error("inactive endpoint answered");
    a_done_flag_rise: assert property (@(posedge aclk)
        disable iff (!aresetn)
        xfer_done[5] && !(do_wr && w_q[B_ARM])
        |=> xfer_done_flag[5] && !ep_arm[5])
        else $error("finished flag missed");
endmodule : uec_ep_ctrl

// File: src/uec_pkg.sv
// Purpose: Constants for the endpoint control block.
// Assumes: AXI4-Lite with 32-bit data, one word per register.
// Notes:   Endpoint n control registers sit at base plus n times the stride.
package uec_pkg;
    localparam int          NUM_EP        = 6;
    localparam logic [11:0] IN_CTL_BASE   = 12'h900;
    localparam logic [11:0] OUT_CTL_BASE  = 12'hb00;
    localparam logic [11:0] EP_STRIDE     = 12'h020;
    localparam logic [11:0] IRQ_EN_BASE   = 12'hc00;
    localparam logic [11:0] FLAG_BASE     = 12'hc80;
    localparam logic [11:0] GNAK_OFFSET   = 12'hd00;
    localparam logic [31:0] EP0_RESET     = 32'h0000_8000;
    localparam logic [31:0] EPN_RESET     = 32'h0000_0000;
    localparam int B_ARM      = 31;
    localparam int B_DIS      = 30;
    localparam int B_SET_ODD  = 29;
    localparam int B_SET_EVEN = 28;
    localparam int B_NAK_SET_STROBE     = 27;
    localparam int B_NAK_CLEAR_STROBE     = 26;
    localparam int B_TXF_LO   = 22;
    localparam int B_STALL    = 21;
    localparam int B_SNOOP    = 20;
    localparam int B_TYPE_LO  = 18;
    localparam int B_NAK_STATE     = 17;
    localparam int B_PAR      = 16;
    localparam int B_ACT      = 15;
    localparam int B_DISF     = 1;
    localparam int B_DONEF    = 0;
    localparam logic [1:0] TYPE_CTRL = 2'h0;
    localparam logic [1:0] TYPE_ISO  = 2'h1;
    localparam logic [1:0] TYPE_BULK = 2'h2;
    localparam logic [1:0] TYPE_INTR = 2'h3;
    typedef enum logic [2:0]
    {
        HS_NONE  = 3'h1,
        HS_NAK   = 3'h2,
        HS_STALL = 3'h4
    } uec_hs_t;
endpackage : uec_pkg
